// File: bench/serial_rtc_sram_access_tb_top.sv
// self-checking bench for the serial clock and ram block
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module serial_rtc_sram_access_tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic oscTick = 1'b0;
  logic auxResetA_n = 1'b1;
  logic auxResetB_n = 1'b1;
  logic belowDeselect = 1'b0;
  logic belowSwitchover = 1'b0;
  wire chipEnable_n, serialClk, serial_in, serial_out, serialOutEn, resetOut, resetOutEn, onBattery, writeLocked;
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic [7:0] eq[$];
  always #12.5 sys_clk = ~sys_clk;
  srtc_spi_master u_master (.sys_clk(sys_clk), .chipEnable_n(chipEnable_n), .serialClk(serialClk),
    .serial_in(serial_in), .serial_out(serial_out), .serialOutEn(serialOutEn));
  srtc_top #(.RECOVERY_CYCLES(200), .DEBOUNCE_CYCLES(4)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .oscTick(oscTick), .chipEnable_n(chipEnable_n), .serialClk(serialClk), .serial_in(serial_in),
    .serial_out(serial_out), .serialOutEn(serialOutEn), .aux_reset_in_a_n(auxResetA_n),
    .aux_reset_in_b_n(auxResetB_n), .resetOut(resetOut), .resetOutEn(resetOutEn),
    .belowDeselect(belowDeselect), .belowSwitchover(belowSwitchover), .onBattery(onBattery),
    .writeLocked(writeLocked));
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic giveUp();
    mismatches++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done();
  endtask
  task automatic writeBurst(input logic [6:0] addr);
    logic [7:0] junk;
    u_master.select();
    u_master.xfer({1'b1, addr}, junk);
    foreach (wq[i]) u_master.xfer(wq[i], junk);
    u_master.deselect();
  endtask
  task automatic readBurst(input logic [6:0] addr, input int n);
    logic [7:0] rx;
    rq.delete();
    u_master.select();
    u_master.xfer({1'b0, addr}, rx);
    repeat (n)
    begin
      u_master.xfer(8'h00, rx);
      rq.push_back(rx);
    end
    u_master.deselect();
    `CHK(serialOutEn, 1'b0)
  endtask
  // one hundredth step carries through the calendar
  task automatic testRollover(input logic [7:0] year, input logic [7:0] expDate, input logic [7:0] expMonth);
    wq = '{8'h99, 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, year};
    writeBurst(7'h00);
    repeat ((srtc_pkg::OSC_HZ + srtc_pkg::HUND_PER_SEC - 1) / srtc_pkg::HUND_PER_SEC)
    begin
      oscTick = 1'b1;
      @(negedge sys_clk);
      oscTick = 1'b0;
      @(negedge sys_clk);
    end
    readBurst(7'h00, 8);
    eq = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, expDate, expMonth, year};
    foreach (eq[i]) `CHK(rq[i], eq[i])
    $display("rollover test done, year %h", year);
  endtask
  // address bit 6 ignored, pointer wraps to zero
  task automatic testRam();
    wq = '{8'ha5, 8'h3c};
    writeBurst(7'h7e);
    readBurst(7'h3e, 3);
    eq = '{8'ha5, 8'h3c, 8'h00};
    foreach (eq[i]) `CHK(rq[i], eq[i])
    $display("ram wrap test done");
  endtask
  // no write lands while supply is low or recovering
  task automatic testLockout();
    int n;
    n = 0;
    wq = '{8'h5a};
    writeBurst(7'h30);
    belowDeselect = 1'b1;
    belowSwitchover = 1'b1;
    @(negedge sys_clk);
    `CHK(onBattery, 1'b1)
    wq = '{8'h11};
    writeBurst(7'h30);
    belowSwitchover = 1'b0;
    belowDeselect = 1'b0;
    @(negedge sys_clk);
    `CHK(onBattery, 1'b0)
    `CHK(writeLocked, 1'b1)
    wq = '{8'h33};
    writeBurst(7'h30);
    while (writeLocked !== 1'b0 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 1000) giveUp();
    readBurst(7'h30, 1);
    `CHK(rq[0], 8'h5a)
    wq = '{8'h22};
    writeBurst(7'h30);
    readBurst(7'h30, 1);
    `CHK(rq[0], 8'h22)
    $display("lockout test done");
  endtask
  // glitch filtered, held level gives one full reset pulse
  task automatic testAux(input bit useB);
    int n;
    n = 0;
    {auxResetB_n, auxResetA_n} = useB ? 2'b01 : 2'b10;
    repeat (2) @(negedge sys_clk);
    {auxResetB_n, auxResetA_n} = 2'b11;
    repeat (10) @(negedge sys_clk);
    `CHK(resetOutEn, 1'b0)
    {auxResetB_n, auxResetA_n} = useB ? 2'b01 : 2'b10;
    repeat (12) @(negedge sys_clk);
    {auxResetB_n, auxResetA_n} = 2'b11;
    `CHK(resetOutEn, 1'b1)
    `CHK(resetOut, 1'b0)
    while (resetOutEn === 1'b1 && n < 4000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 4000) giveUp();
    `CHK(n >= srtc_pkg::RST_PULSE_CYC - 20 && n <= srtc_pkg::RST_PULSE_CYC, 1'b1)
    $display("aux reset test done, input %0d", useB);
  endtask
  // supply dip mid-read ends the access while still selected
  task automatic testAbort();
    logic [7:0] rx;
    u_master.select();
    u_master.xfer(8'h05, rx);
    u_master.xfer(8'h00, rx);
    `CHK(serialOutEn, 1'b1)
    belowDeselect = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(serialOutEn, 1'b0)
    belowDeselect = 1'b0;
    u_master.deselect();
    `CHK(rx, 8'h29)
    $display("abort test done");
  endtask
  initial
  begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    testRollover(8'h23, 8'h01, 8'h03);
    testRollover(8'h24, 8'h29, 8'h02);
    testRam();
    testLockout();
    testAbort();
    testAux(1'b0);
    testAux(1'b1);
    test_done();
  end
endmodule

// File: bench/srtc_spi_master.sv
// spi master model, mode 0, clock idles low outside frames
`timescale 1ns/1ps
module srtc_spi_master (
  input wire logic sys_clk,
  output logic chipEnable_n,
  output logic serialClk,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serialOutEn
);
  localparam int HALF = 4;
  wire sdoWire;
  assign sdoWire = serialOutEn ? serial_out : 1'bz;
  initial
  begin
    chipEnable_n = 1'b1;
    serialClk = 1'b0;
    serial_in = 1'b0;
  end
  task automatic select();
    repeat (HALF) @(negedge sys_clk);
    chipEnable_n = 1'b0;
    repeat (HALF) @(negedge sys_clk);
  endtask
  // released data line shows the inverse of its last bit
  task automatic deselect();
    repeat (HALF) @(negedge sys_clk);
    chipEnable_n = 1'b1;
    serial_in = ~serial_in;
    repeat (HALF) @(negedge sys_clk);
  endtask
  // msb first, data set while low, both sides sample at the rise
  task automatic xfer(input logic [7:0] txByte, output logic [7:0] rxByte);
    for (int i = 7; i >= 0; i--)
    begin
      serial_in = txByte[i];
      repeat (HALF) @(negedge sys_clk);
      rxByte[i] = sdoWire;
      serialClk = 1'b1;
      repeat (HALF) @(negedge sys_clk);
      serialClk = 1'b0;
    end
  endtask
endmodule

// File: bench/srtc_top_properties.sv
// concurrent checks on the serial clock and ram block ports
`timescale 1ns/1ps
module srtc_top_properties #(
  parameter int unsigned RECOVERY_CYCLES = 8000,
  parameter int unsigned DEBOUNCE_CYCLES = 800
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic oscTick,
  input wire logic chipEnable_n,
  input wire logic serialClk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serialOutEn,
  input wire logic aux_reset_in_a_n,
  input wire logic aux_reset_in_b_n,
  input wire logic resetOut,
  input wire logic resetOutEn,
  input wire logic belowDeselect,
  input wire logic belowSwitchover,
  input wire logic onBattery,
  input wire logic writeLocked
);
  localparam int LOCK_HI = RECOVERY_CYCLES + 4;
  localparam int DEB_HI = DEBOUNCE_CYCLES + 3;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // cycles spent locked since supply came back
  logic [31:0] lockCnt_r;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      lockCnt_r <= 32'h0;
    else if (belowDeselect || !writeLocked)
      lockCnt_r <= 32'h0;
    else
      lockCnt_r <= lockCnt_r + 32'h1;
  end
  property p_deselFloat;
    chipEnable_n [*3] |-> !serialOutEn;
  endproperty
  a_deselFloat: assert property (p_deselFloat) else $error("output driven while deselected");
  property p_drainLow;
    resetOut == 1'b0;
  endproperty
  a_drainLow: assert property (p_drainLow) else $error("reset line data not low");
  property p_battery;
    onBattery == belowSwitchover;
  endproperty
  a_battery: assert property (p_battery) else $error("battery state wrong");
  property p_abortFloat;
    belowDeselect [*3] |-> !serialOutEn;
  endproperty
  a_abortFloat: assert property (p_abortFloat) else $error("access not aborted");
  property p_lockHold;
    $fell(belowDeselect) |-> writeLocked [*8];
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("writes unlocked too early");
  property p_lockEnds;
    lockCnt_r <= LOCK_HI;
  endproperty
  a_lockEnds: assert property (p_lockEnds) else $error("write lock never ends");
  property p_debA;
    !aux_reset_in_a_n [*8] |-> ##[0:DEB_HI] resetOutEn;
  endproperty
  a_debA: assert property (p_debA) else $error("first aux input ignored");
  property p_debB;
    !aux_reset_in_b_n [*8] |-> ##[0:DEB_HI] resetOutEn;
  endproperty
  a_debB: assert property (p_debB) else $error("second aux input ignored");
  property p_pulseLen;
    $rose(resetOutEn) |-> resetOutEn [*8];
  endproperty
  a_pulseLen: assert property (p_pulseLen) else $error("reset pulse too short");
  property p_shiftFall;
    serialOutEn && $past(serialOutEn) && $changed(serial_out) |-> !serialClk;
  endproperty
  a_shiftFall: assert property (p_shiftFall) else $error("output moved while clock high");
  cover property ($rose(serialOutEn));
  cover property ($fell(writeLocked));
  cover property ($rose(resetOutEn));
endmodule

bind srtc_top srtc_top_properties #(.RECOVERY_CYCLES(RECOVERY_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .oscTick(oscTick), .chipEnable_n(chipEnable_n),
  .serialClk(serialClk), .serial_in(serial_in), .serial_out(serial_out), .serialOutEn(serialOutEn),
  .aux_reset_in_a_n(aux_reset_in_a_n), .aux_reset_in_b_n(aux_reset_in_b_n), .resetOut(resetOut),
  .resetOutEn(resetOutEn), .belowDeselect(belowDeselect), .belowSwitchover(belowSwitchover),
  .onBattery(onBattery), .writeLocked(writeLocked));

// File: hw/srtc_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module srtc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic push, pop;

  assign inReady = (wrPtr_r - rdPtr_r) != (PW+1)'(DEPTH);
  assign outValid = wrPtr_r != rdPtr_r;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_r[PW-1:0]];

  always_comb
  begin
    wrPtr_nxt = wrPtr_r + (PW+1)'(push);
    rdPtr_nxt = rdPtr_r + (PW+1)'(pop);
    if (flush)
    begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wrPtr_r[PW-1:0]] <= inData;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end
endmodule

// File: hw/srtc_pkg.sv
// shared constants for the serial clock and ram block
package srtc_pkg;
  localparam int unsigned SYS_CLK_HZ = 40000000;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned HUND_PER_SEC = 100;
  localparam int unsigned MEM_WORDS = 64;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  // byte positions in the storage map
  localparam logic [5:0] ADR_HUND = 6'h00;
  localparam logic [5:0] ADR_SEC = 6'h01;
  localparam logic [5:0] ADR_MIN = 6'h02;
  localparam logic [5:0] ADR_HOUR = 6'h03;
  localparam logic [5:0] ADR_DAY = 6'h04;
  localparam logic [5:0] ADR_DATE = 6'h05;
  localparam logic [5:0] ADR_MONTH = 6'h06;
  localparam logic [5:0] ADR_YEAR = 6'h07;
  localparam int unsigned CLOCK_BYTES = 8;
  localparam int unsigned CTRL_BYTES = 12;
  // bcd limits
  localparam logic [7:0] BCD_HUND_MAX = 8'h99;
  localparam logic [7:0] BCD_SEC_MAX = 8'h59;
  localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
  localparam logic [7:0] BCD_DAY_MAX = 8'h07;
  localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_FEB = 8'h02;
  localparam logic [7:0] BCD_APR = 8'h04;
  localparam logic [7:0] BCD_JUN = 8'h06;
  localparam logic [7:0] BCD_SEP = 8'h09;
  localparam logic [7:0] BCD_NOV = 8'h11;
  localparam logic [7:0] BCD_D28 = 8'h28;
  localparam logic [7:0] BCD_D29 = 8'h29;
  localparam logic [7:0] BCD_D30 = 8'h30;
  localparam logic [7:0] BCD_D31 = 8'h31;
  localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
  localparam logic [1:0] CENT_MASK = 2'h3;
  localparam int unsigned CENT_LSB = 6;
  // aux reset filtering and pulse length
  localparam int unsigned DEBOUNCE_US = 20;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * (SYS_CLK_HZ / 1000000));
  localparam int unsigned RST_PULSE_US = 40;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_US * (SYS_CLK_HZ / 1000000));
  // write lockout after power returns
  localparam int unsigned RECOVERY_US = 200;
  localparam int unsigned RECOVERY_CYC = (RECOVERY_US * (SYS_CLK_HZ / 1000000));
endpackage

// File: hw/srtc_top.sv
// serial clock calendar with 64 byte store and spi slave
`timescale 1ns/1ps
// Notes on behaviour
// - sixty-four bytes of eight bits, all reachable over the serial link.
// - time base comes from a 32768 Hz oscillator tick.
// - eight bytes hold clock and calendar in bcd.
// - twelve further bytes follow as plain storage; no alarm, watchdog or square-wave logic acts on them.
// - byte address steps by one after each data byte read or written.
// - century, year, month, date, day, hour, minute, second, hundredths, 24-hour bcd.
// - month lengths corrected, leap years as every fourth year to 2100.
// - two aux reset inputs debounced; either drives the open-drain reset output.
// - slave only, active only while chip enable is low.
// - msb first; input sampled on each rising serial clock while selected.
// - sequential order clock bytes, control bytes, then user ram to 64.
// - below deselect threshold the access aborts and address clears.
// - below deselect threshold all interface inputs are ignored.
// - below switch-over threshold run from battery, clock keeps counting.
// - above switch-over threshold leave battery, use main supply.
// - writes stay blocked until supply is good plus recovery delay.
// - first bit 1 writes, 0 reads; seven address bits then data bytes.
// - mode 0 or 3; latch on rising edge, shift out on falling.
// - address bit 6 is ignored.
// - chip enable high deselects and floats the serial output.
module srtc_top #(
  parameter int unsigned RECOVERY_CYCLES = srtc_pkg::RECOVERY_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = srtc_pkg::DEBOUNCE_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic oscTick,
  input wire logic chipEnable_n,
  input wire logic serialClk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serialOutEn,
  input wire logic aux_reset_in_a_n,
  input wire logic aux_reset_in_b_n,
  output logic resetOut,
  output logic resetOutEn,
  input wire logic belowDeselect,
  input wire logic belowSwitchover,
  output logic onBattery,
  output logic writeLocked
);
  localparam int AW = srtc_pkg::ADDR_W;
  localparam int DW = srtc_pkg::DATA_W;
  typedef enum logic [1:0] {S_IDLE, S_CMD, S_WDATA, S_RDATA} srtc_state_e;

  logic [DW-1:0] mem [srtc_pkg::MEM_WORDS];
  srtc_state_e state_r, state_nxt;
  logic sclkPrev_r, sclkPrev_nxt;
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic [DW-1:0] shIn_r, shIn_nxt, shOut_r, shOut_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic outEn_r, outEn_nxt, outBit_r, outBit_nxt;
  logic [31:0] recCnt_r, recCnt_nxt;
  logic [15:0] prescale_r, prescale_nxt;
  logic hundTick;
  logic [DW-1:0] inByte;
  logic rise, fall, sel;
  logic fifoInValid, fifoInReady, fifoOutValid;
  logic [AW+DW-1:0] fifoOutData;
  logic [31:0] dbA_r, dbA_nxt, dbB_r, dbB_nxt, pulse_r, pulse_nxt;

  assign sel = !chipEnable_n && !belowDeselect;
  assign rise = sel && serialClk && !sclkPrev_r;
  assign fall = sel && !serialClk && sclkPrev_r;
  assign inByte = {shIn_r[DW-2:0], serial_in};
  assign onBattery = belowSwitchover;
  assign writeLocked = recCnt_r != 32'h0;
  assign serialOutEn = outEn_r;
  assign serial_out = outBit_r;
  assign fifoInValid = (state_r == S_WDATA) && rise && (bitCnt_r == 3'h7) && !writeLocked && fifoInReady;

  always_comb
  begin
    state_nxt = state_r;
    sclkPrev_nxt = serialClk;
    bitCnt_nxt = bitCnt_r;
    shIn_nxt = shIn_r;
    shOut_nxt = shOut_r;
    addr_nxt = addr_r;
    outEn_nxt = outEn_r;
    outBit_nxt = outBit_r;
    if (!sel)
    begin
      state_nxt = S_IDLE;
      outEn_nxt = 1'b0;
      bitCnt_nxt = 3'h0;
      if (belowDeselect)
        addr_nxt = '0;
    end
    else
    begin
      if (state_r == S_IDLE)
        state_nxt = S_CMD;
      // msb first sampling on rising edge
      if (rise)
      begin
        shIn_nxt = inByte;
        bitCnt_nxt = bitCnt_r + 3'h1;
        if (bitCnt_r == 3'h7)
        begin
          case (state_r)
            S_IDLE, S_CMD:
            begin
              // direction bit then address, bit 6 dropped
              addr_nxt = inByte[AW-1:0];
              if (inByte[DW-1])
                state_nxt = S_WDATA;
              else
              begin
                state_nxt = S_RDATA;
                shOut_nxt = mem[inByte[AW-1:0]];
              end
            end
            S_WDATA:
              // step after each byte, natural wrap
              addr_nxt = addr_r + AW'(1);
            S_RDATA:
            begin
              addr_nxt = addr_r + AW'(1);
              shOut_nxt = mem[addr_r + AW'(1)];
            end
            default:
              state_nxt = S_IDLE;
          endcase
        end
      end
      if (fall && state_r == S_RDATA)
      begin
        outEn_nxt = 1'b1;
        outBit_nxt = shOut_r[DW-1];
        shOut_nxt = {shOut_r[DW-2:0], 1'b0};
      end
    end
  end

  always_comb
  begin
    prescale_nxt = prescale_r;
    hundTick = 1'b0;
    if (oscTick)
    begin
      // accumulator gives 100 steps per 32768 ticks
      if (prescale_r + 16'(srtc_pkg::HUND_PER_SEC) >= 16'(srtc_pkg::OSC_HZ))
      begin
        prescale_nxt = prescale_r + 16'(srtc_pkg::HUND_PER_SEC) - 16'(srtc_pkg::OSC_HZ);
        hundTick = 1'b1;
      end
      else
        prescale_nxt = prescale_r + 16'(srtc_pkg::HUND_PER_SEC);
    end
  end

  always_comb
  begin
    recCnt_nxt = recCnt_r;
    if (belowDeselect)
      recCnt_nxt = RECOVERY_CYCLES;
    else if (recCnt_r != 32'h0)
      recCnt_nxt = recCnt_r - 32'h1;
  end

  // debounce both aux inputs, stretch reset
  always_comb
  begin
    dbA_nxt = aux_reset_in_a_n ? 32'h0 : ((dbA_r < DEBOUNCE_CYCLES) ? dbA_r + 32'h1 : dbA_r);
    dbB_nxt = aux_reset_in_b_n ? 32'h0 : ((dbB_r < DEBOUNCE_CYCLES) ? dbB_r + 32'h1 : dbB_r);
    pulse_nxt = (pulse_r != 32'h0) ? pulse_r - 32'h1 : 32'h0;
    if ((dbA_r == DEBOUNCE_CYCLES - 1) || (dbB_r == DEBOUNCE_CYCLES - 1))
      pulse_nxt = srtc_pkg::RST_PULSE_CYC;
  end
  assign resetOut = 1'b0;
  assign resetOutEn = pulse_r != 32'h0;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= S_IDLE;
      sclkPrev_r <= 1'b0;
      bitCnt_r <= 3'h0;
      shIn_r <= '0;
      shOut_r <= '0;
      addr_r <= '0;
      outEn_r <= 1'b0;
      outBit_r <= 1'b0;
      recCnt_r <= 32'h0;
      prescale_r <= 16'h0;
      dbA_r <= 32'h0;
      dbB_r <= 32'h0;
      pulse_r <= 32'h0;
    end
    else
    begin
      state_r <= state_nxt;
      sclkPrev_r <= sclkPrev_nxt;
      bitCnt_r <= bitCnt_nxt;
      shIn_r <= shIn_nxt;
      shOut_r <= shOut_nxt;
      addr_r <= addr_nxt;
      outEn_r <= outEn_nxt;
      outBit_r <= outBit_nxt;
      recCnt_r <= recCnt_nxt;
      prescale_r <= prescale_nxt;
      dbA_r <= dbA_nxt;
      dbB_r <= dbB_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  // received bytes wait here before reaching storage
  srtc_fifo #(.WIDTH(AW+DW), .DEPTH(srtc_pkg::FIFO_DEPTH)) u_wfifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .flush(belowDeselect),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({addr_r, inByte}),
    .outValid(fifoOutValid),
    .outReady(!hundTick),
    .outData(fifoOutData)
  );

  // bcd increment helper
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] monthLen(input logic [7:0] m, input logic [7:0] y);
    if (m == srtc_pkg::BCD_FEB)
      // leap when bcd year divisible by four
      monthLen = ((y[4] ? y[1:0] == 2'h2 : y[1:0] == 2'h0)) ? srtc_pkg::BCD_D29 : srtc_pkg::BCD_D28;
    else if (m == srtc_pkg::BCD_APR || m == srtc_pkg::BCD_JUN || m == srtc_pkg::BCD_SEP || m == srtc_pkg::BCD_NOV)
      monthLen = srtc_pkg::BCD_D30;
    else
      monthLen = srtc_pkg::BCD_D31;
  endfunction

  // next hour value, only its low six bits are used
  logic [7:0] hourInc;
  assign hourInc = bcdInc({2'h0, mem[srtc_pkg::ADR_HOUR][5:0]});

  // storage, map order, bcd carry chain
  always_ff @(posedge sys_clk)
  begin
    if (hundTick)
    begin
      mem[srtc_pkg::ADR_HUND] <= (mem[srtc_pkg::ADR_HUND] == srtc_pkg::BCD_HUND_MAX) ? 8'h00
        : bcdInc(mem[srtc_pkg::ADR_HUND]);
      if (mem[srtc_pkg::ADR_HUND] == srtc_pkg::BCD_HUND_MAX)
      begin
        mem[srtc_pkg::ADR_SEC] <= (mem[srtc_pkg::ADR_SEC] == srtc_pkg::BCD_SEC_MAX) ? 8'h00
          : bcdInc(mem[srtc_pkg::ADR_SEC]);
        if (mem[srtc_pkg::ADR_SEC] == srtc_pkg::BCD_SEC_MAX)
        begin
          mem[srtc_pkg::ADR_MIN] <= (mem[srtc_pkg::ADR_MIN] == srtc_pkg::BCD_SEC_MAX) ? 8'h00
            : bcdInc(mem[srtc_pkg::ADR_MIN]);
          if (mem[srtc_pkg::ADR_MIN] == srtc_pkg::BCD_SEC_MAX)
          begin
            if (mem[srtc_pkg::ADR_HOUR][5:0] == srtc_pkg::BCD_HOUR_MAX[5:0])
            begin
              mem[srtc_pkg::ADR_HOUR][5:0] <= 6'h00;
              mem[srtc_pkg::ADR_DAY] <= (mem[srtc_pkg::ADR_DAY] == srtc_pkg::BCD_DAY_MAX) ? srtc_pkg::BCD_ONE
                : bcdInc(mem[srtc_pkg::ADR_DAY]);
              if (mem[srtc_pkg::ADR_DATE] == monthLen(mem[srtc_pkg::ADR_MONTH], mem[srtc_pkg::ADR_YEAR]))
              begin
                mem[srtc_pkg::ADR_DATE] <= srtc_pkg::BCD_ONE;
                mem[srtc_pkg::ADR_MONTH] <= (mem[srtc_pkg::ADR_MONTH] == srtc_pkg::BCD_MONTH_MAX)
                  ? srtc_pkg::BCD_ONE : bcdInc(mem[srtc_pkg::ADR_MONTH]);
                if (mem[srtc_pkg::ADR_MONTH] == srtc_pkg::BCD_MONTH_MAX)
                begin
                  mem[srtc_pkg::ADR_YEAR] <= (mem[srtc_pkg::ADR_YEAR] == srtc_pkg::BCD_YEAR_MAX) ? 8'h00
                    : bcdInc(mem[srtc_pkg::ADR_YEAR]);
                  if (mem[srtc_pkg::ADR_YEAR] == srtc_pkg::BCD_YEAR_MAX)
                    mem[srtc_pkg::ADR_HOUR][7:6] <= mem[srtc_pkg::ADR_HOUR][7:6] + 2'h1;
                end
              end
              else
                mem[srtc_pkg::ADR_DATE] <= bcdInc(mem[srtc_pkg::ADR_DATE]);
            end
            else
              mem[srtc_pkg::ADR_HOUR][5:0] <= hourInc[5:0];
          end
        end
      end
    end
    else if (fifoOutValid)
      mem[fifoOutData[AW+DW-1:DW]] <= fifoOutData[DW-1:0];
  end
endmodule
